// >>> src/manchester_rx_defines.svh
// Purpose: Timing and protocol constants for the Manchester receive decoder.
// Assumes: ref_clk runs at 20 MHz, so one sample covers half a bit cell.
// Notes:   Cycle counts are derived from the times at the clock period.
`ifndef MANCHESTER_RX_DEFINES_SVH
`define MANCHESTER_RX_DEFINES_SVH

`define CLK_PERIOD_NS 50
`define RX_REJECT_NS 20
`define RX_QUAL_CYC ((`RX_REJECT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COL_REJECT_NS 10
`define COL_QUAL_CYC ((`COL_REJECT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COL_HOLD_NS 190
`define COL_HOLD_CYC (`COL_HOLD_NS / `CLK_PERIOD_NS)
`define NEG_EDGES_TO_LOCK 2'h2
`define EOP_QUIET 2'h1
`define QUIET_MAX 2'h3

`endif

// >>> src/manchester_rx_pkg.sv
// Purpose: Types shared by the Manchester receive decoder.
// Assumes: Nothing beyond the defines header.
// Notes:   Line pairs and most host outputs travel as packed structs; testSelect and transmitBitClock are separate.
package manchester_rx_pkg;

	typedef struct packed {
		logic rxSquelch;
		logic rxData;
		logic colSquelch;
	} lineIn_t;

	typedef struct packed {
		logic carrierPresentOut;
		logic collisionFlag;
		logic recClock;
		logic recData;
	} hostOut_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACQUIRE,
		ST_RECEIVE,
		ST_DRAIN
	} rxState_t;

endpackage : manchester_rx_pkg

// >>> src/pulse_qualifier.sv
// Purpose: Passes a squelch level only after it has held for QUAL samples.
// Assumes: The level is synchronous to clk.
// Notes:   Dropping the level clears the output at once.
`timescale 1ns/1ps
module pulse_qualifier #(
	parameter int unsigned QUAL = 1
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Level in
	input  wire logic level,
	// Qualified level and its rising pulse
	output logic      qualOut,
	output logic      riseOut
);

	logic [2:0] cnt_q;
	logic       qual_q;
	logic       rise_q;

	wire logic qualD = level && (cnt_q >= 3'(QUAL - 1));
	wire logic atMax = (cnt_q == 3'h7);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q  <= 3'h0;
			qual_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			cnt_q  <= level ? cnt_q + {2'h0, !atMax} : 3'h0;
			qual_q <= qualD;
			rise_q <= qualD && !qual_q;
		end
	end

	assign qualOut = qual_q;
	assign riseOut = rise_q;

endmodule : pulse_qualifier

// >>> src/manchester_rx_decoder.sv
// Purpose: Receive side of a 10 Mb/s Manchester line interface.
// Assumes: Line comparators give synchronous levels; ref_clk is 20 MHz.
// Notes:   Two samples per bit cell, so edge jitter snaps to one sample.
//
// How it works
// - Receive activity shorter than 20ns never raises carrier or starts data.
// - Collision transients shorter than 10ns never raise the collision flag.
// - Receive pulses of 45ns or more always qualify; 20ns or less never.
// - Carrier goes high once amplitude and duration both qualify.
// - Recovered clock and data start after the third negative data edge.
// - During reception recovered data changes only at recovered clock rise.
// - At packet end carrier drops, clock gives one last cycle, then low with test select high.
// - With test select low the recovered clock always runs.
// - Clock locks to transmit clock rate and aligns phase to edges.
// - Bits are recovered despite edges displaced up to 20ns.
// - Collision flag holds three samples (150ns) after the last collision rise.
// - Idle line with test select high holds recovered data high.
// - Idle line with test select high holds recovered clock low.
// - Carrier drops together with a recovered clock rising edge.
// - Collision flag stays low with no collision signal.
`timescale 1ns/1ps
`include "manchester_rx_defines.svh"
module manchester_rx_decoder
	import manchester_rx_pkg::*;
(
	// Clock and reset
	input  wire logic    ref_clk,
	input  wire logic    resetn,
	// Line side
	input  wire lineIn_t line,
	input  wire logic    testSelect,
	// Host side
	output hostOut_t     host,
	output logic         transmitBitClock
);

	logic       rxQual;
	logic       rxRise;
	logic       colQual;
	logic       colRise;
	logic       dataPrev_q;
	logic       transPrev_q;
	logic       phase_q;
	logic       tbc_q;
	logic [1:0] negCnt_q;
	logic [1:0] quietCnt_q;
	logic [2:0] holdCnt_q;
	rxState_t   state_q;
	rxState_t   state_d;
	hostOut_t   host_q;
	hostOut_t   host_d;

	// Short squelch activity is filtered before anything else sees it.
	pulse_qualifier #(.QUAL(`RX_QUAL_CYC)) u_rxQual (
		.clk    (ref_clk),
		.resetn (resetn),
		.level  (line.rxSquelch),
		.qualOut(rxQual),
		.riseOut(rxRise)
	);

	pulse_qualifier #(.QUAL(`COL_QUAL_CYC)) u_colQual (
		.clk    (ref_clk),
		.resetn (resetn),
		.level  (line.colSquelch),
		.qualOut(colQual),
		.riseOut(colRise)
	);

	// Data edges only count once carrier is qualified.
	wire logic trans    = rxQual && (line.rxData != dataPrev_q);
	wire logic negEdge  = trans && dataPrev_q;
	// An edge after a quiet sample must be mid-cell; resync phase there.
	wire logic resync   = trans && !transPrev_q;
	wire logic phaseNow = resync || phase_q;
	wire logic quietEnd = (!trans && (quietCnt_q == `EOP_QUIET)) || !rxQual;
	wire logic lockNow  = negEdge && (negCnt_q == `NEG_EDGES_TO_LOCK);
	wire logic inRecv   = (state_q == ST_RECEIVE);
	wire logic isIdle   = (state_q == ST_IDLE);
	wire logic idleClk  = testSelect ? 1'b0 : tbc_q;
	wire logic holdOn   = (holdCnt_q > 3'h1);

	always_comb begin
		state_d = state_q;
		host_d  = host_q;
		host_d.collisionFlag = colRise || holdOn;
		case (state_q)
			ST_IDLE: begin
				host_d.recClock = idleClk;
				if (testSelect) begin
					host_d.recData = 1'b1;
				end
				// Start on the qualified rise, not the level, so the squelch
				// tail after packet end cannot raise carrier a second time.
				if (rxRise) begin
					host_d.carrierPresentOut = 1'b1;
					state_d = ST_ACQUIRE;
				end
			end
			ST_ACQUIRE: begin
				host_d.recClock = idleClk;
				if (lockNow) begin
					state_d = ST_RECEIVE;
					host_d.recClock = 1'b1;
					host_d.recData  = line.rxData;
				end else if (quietEnd) begin
					state_d = ST_DRAIN;
				end
			end
			ST_RECEIVE: begin
				host_d.recClock = phaseNow;
				if (phaseNow && trans) begin
					host_d.recData = line.rxData;
				end
				if (quietEnd) begin
					state_d = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				// One last clock cycle, carrier falling on its rising edge.
				host_d.recClock = phaseNow;
				if (phaseNow) begin
					host_d.carrierPresentOut = 1'b0;
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			dataPrev_q  <= 1'b1;
			transPrev_q <= 1'b0;
			phase_q     <= 1'b0;
			tbc_q       <= 1'b0;
			state_q     <= ST_IDLE;
			host_q      <= '0;
			host_q.recData <= 1'b1;
		end else begin
			dataPrev_q  <= line.rxData;
			transPrev_q <= trans;
			phase_q     <= !phaseNow;
			tbc_q       <= !tbc_q;
			state_q     <= state_d;
			host_q      <= host_d;
		end
	end

	// Counters: lock edges, quiet samples, and the collision hold time.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			negCnt_q   <= 2'h0;
			quietCnt_q <= 2'h0;
			holdCnt_q  <= 3'h0;
		end else begin
			negCnt_q   <= (state_q == ST_ACQUIRE) ?
			              negCnt_q + {1'b0, negEdge} : 2'h0;
			quietCnt_q <= trans ? 2'h0 :
			              quietCnt_q + {1'b0, quietCnt_q != `QUIET_MAX};
			holdCnt_q  <= colRise ? 3'(`COL_HOLD_CYC) :
			              holdCnt_q - {2'h0, holdCnt_q != 3'h0};
		end
	end

	assign host             = host_q;
	assign transmitBitClock = tbc_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence s_idleTest2;
		(isIdle && testSelect)[*2];
	endsequence

	sequence s_colQuiet;
		(!colQual)[*5];
	endsequence

	sequence s_dropTest;
		$fell(host.carrierPresentOut) && testSelect;
	endsequence

	property p_noShortCarrier;
		$rose(host.carrierPresentOut) |->
			$past(rxQual) && $past(line.rxSquelch, 2);
	endproperty
	a_noShortCarrier: assert property (p_noShortCarrier)
		else $error("carrier rose without qualified activity");

	property p_acceptPulse;
		isIdle && line.rxSquelch |-> ##[1:2] host.carrierPresentOut;
	endproperty
	a_acceptPulse: assert property (p_acceptPulse)
		else $error("qualified pulse did not raise carrier");

	property p_noShortCol;
		$rose(host.collisionFlag) |-> $past(colRise);
	endproperty
	a_noShortCol: assert property (p_noShortCol)
		else $error("collision flag rose without qualified rise");

	property p_colHold;
		colRise |=> host.collisionFlag[*3];
	endproperty
	a_colHold: assert property (p_colHold)
		else $error("collision flag not held after rise");

	property p_colIdleLow;
		s_colQuiet |-> !host.collisionFlag;
	endproperty
	a_colIdleLow: assert property (p_colIdleLow)
		else $error("collision flag high with no collision signal");

	property p_idleData;
		s_idleTest2 |-> host.recData;
	endproperty
	a_idleData: assert property (p_idleData)
		else $error("recovered data not high while idle");

	property p_idleClock;
		s_idleTest2 |-> !host.recClock;
	endproperty
	a_idleClock: assert property (p_idleClock)
		else $error("recovered clock not low while idle");

	property p_dataOnRise;
		$changed(host.recData) && $past(inRecv) |-> $rose(host.recClock);
	endproperty
	a_dataOnRise: assert property (p_dataOnRise)
		else $error("recovered data changed off the clock rise");

	property p_lockOnNeg;
		$rose(inRecv) |-> $past(negEdge);
	endproperty
	a_lockOnNeg: assert property (p_lockOnNeg)
		else $error("reception started without a negative edge");

	property p_dropOnRise;
		s_dropTest |-> $rose(host.recClock);
	endproperty
	a_dropOnRise: assert property (p_dropOnRise)
		else $error("carrier dropped off the clock rise");

	property p_clockStops;
		s_dropTest |=> (!host.recClock)[*2];
	endproperty
	a_clockStops: assert property (p_clockStops)
		else $error("recovered clock not low after packet end");

endmodule : manchester_rx_decoder

// >>> tb/manchester_line_partner.sv
// Purpose: Transceiver cable model for the receive and collision pairs.
// Assumes: One ref_clk sample is half a bit cell.
// Notes:   After squelch drops the data pair toggles, so no stale level.
`timescale 1ns/1ps
module manchester_line_partner
	import manchester_rx_pkg::*;
(
	// Clock
	input  wire logic clk,
	// Line pairs
	output lineIn_t   line
);
	initial line = '0;

	task automatic halfBit(input logic v);
		@(posedge clk);
		line.rxData <= v;
	endtask : halfBit

	task automatic sendFrame(input logic bitsIn[$]);
		@(posedge clk);
		line.rxSquelch <= 1'b1;
		foreach (bitsIn[i]) begin
			halfBit(~bitsIn[i]);
			halfBit(bitsIn[i]);
		end
		repeat (3) halfBit(bitsIn[$]);
		@(posedge clk);
		line.rxSquelch <= 1'b0;
		repeat (6) halfBit(~line.rxData);
	endtask : sendFrame

	// A 10 MHz wave is one sample high and one low.
	task automatic collide(input int n);
		repeat (n) begin
			@(posedge clk);
			line.colSquelch <= 1'b1;
			@(posedge clk);
			line.colSquelch <= 1'b0;
		end
	endtask : collide
endmodule : manchester_line_partner

// >>> tb/tb_manchester_rx_decoder_collision_detect.sv
// Purpose: Self-checking bench for the Manchester receive decoder.
// Assumes: Partner model drives the line; bench drives test select.
// Notes:   Bits are compared as the host would latch them on clock rise.
`timescale 1ns/1ps
module tb_manchester_rx_decoder_collision_detect
	import manchester_rx_pkg::*;
;
	logic       ref_clk = 1'b0;
	logic       resetn = 1'b0;
	logic       testSelect = 1'b1;
	lineIn_t    line;
	hostOut_t   host;
	logic       tbc;
	int         miscompares = 0;
	int         numChecks = 0;
	int         cycles = 0;
	logic [7:0] sqHist = 8'h00;
	logic [7:0] colHist = 8'h00;
	logic [7:0] lfsrQ = 8'h4d;
	logic       lastRc = 1'b0;
	logic       lastCar = 1'b0;
	logic       lastData = 1'b1;
	logic       locked = 1'b0;
	logic       v;
	logic       tbcPrev;
	logic       sent[$];
	logic       got[$];

	always #25 ref_clk = ~ref_clk;

	manchester_line_partner cable (.clk(ref_clk), .line(line));
	manchester_rx_decoder DUT (.ref_clk(ref_clk), .resetn(resetn),
		.line(line), .testSelect(testSelect), .host(host),
		.transmitBitClock(tbc));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic check(input string nm, input logic e, input logic g);
		numChecks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	always @(posedge ref_clk) begin
		cycles++;
		sqHist = resetn ? {sqHist[6:0], line.rxSquelch} : 8'h00;
		colHist = resetn ? {colHist[6:0], line.colSquelch} : 8'h00;
		if (cycles > 2000) begin
			miscompares++;
			conclude();
		end
	end

	// Model of the host side, judged half a cycle after each edge.
	always @(negedge ref_clk) if (resetn) begin
		check("collision", (colHist[1] & ~colHist[2]) |
			(colHist[2] & ~colHist[3]) |
			(colHist[3] & ~colHist[4]), host.collisionFlag);
		if (host.carrierPresentOut === 1'b1 && lastCar === 1'b0)
			check("carrierRise", 1'b1, sqHist[1] & ~sqHist[2]);
		if (host.carrierPresentOut === 1'b0 && lastCar === 1'b1)
			check("dropOnRise", 1'b1, host.recClock & ~lastRc);
		if (locked && lastCar === 1'b1 && host.recData !== lastData)
			check("dataOnRise", 1'b1, host.recClock & ~lastRc);
		// The rise that drops carrier only closes the frame; the last bit
		// was already taken on the rise before it.
		if (host.recClock === 1'b1 && lastRc === 1'b0 &&
			host.carrierPresentOut === 1'b1) begin
			if (locked)
				got.push_back(lastData);
			locked = 1'b1;
		end
		lastRc = host.recClock;
		lastCar = host.carrierPresentOut;
		lastData = host.recData;
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		check("idleData", 1'b1, host.recData);
		check("idleClock", 1'b0, host.recClock);
		$display("test idle done");
		for (int p = 0; p < 2; p++) begin
			sent.delete();
			got.delete();
			locked = 1'b0;
			for (int i = 0; i < 8; i++)
				sent.push_back(i % 2 == 0);
			for (int i = 0; i < 16; i++) begin
				lfsrQ = lfsr(lfsrQ);
				sent.push_back(lfsrQ[0]);
			end
			cable.sendFrame(sent);
			repeat (6) @(negedge ref_clk);
			check("bitCount", 1'b1, got.size() >= sent.size() - 7);
			foreach (got[i])
				check("bit", sent[sent.size() - got.size() + i], got[i]);
			check("endClock", 1'b0, host.recClock);
			check("endData", 1'b1, host.recData);
			$display("test packet %0d done", p);
		end
		cable.collide(5);
		cable.collide(1);
		repeat (8) @(posedge ref_clk);
		$display("test collision done");
		testSelect <= 1'b0;
		repeat (3) @(negedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			v = host.recClock;
			tbcPrev = tbc;
			@(negedge ref_clk);
			check("freeClock", ~v, host.recClock);
			check("txClock", ~tbcPrev, tbc);
		end
		$display("test free clock done");
		conclude();
	end
endmodule : tb_manchester_rx_decoder_collision_detect
